// ===== core/tsp_serial_port.v
// Purpose: Synchronous serial port with multiprocessor time-division mode
// Assumes: All pin inputs asynchronous; synchronous active-low reset
// Notes:   Pin edges found by sampling on clk_in; bit clock well below clk_in/4
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "tsp_map.vh"
module tsp_serial_port (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire [2:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  output wire        irq_out,
  output wire        rx_buffer_full_out,
  output wire        tx_buffer_empty_out,
  input  wire        serial_in_line_in,
  input  wire        input_bit_clock_in,
  output wire        input_bit_clock_out,
  output wire        input_bit_clock_oe_out,
  input  wire        input_word_strobe_in,
  output wire        input_word_strobe_out,
  output wire        input_word_strobe_oe_out,
  input  wire        output_bit_clock_in,
  output wire        output_bit_clock_out,
  output wire        output_bit_clock_oe_out,
  input  wire        output_word_strobe_in,
  output wire        output_word_strobe_out,
  output wire        output_word_strobe_oe_out,
  output wire        serial_out_line_out,
  output wire        serial_out_line_oe_out,
  input  wire        serial_addr_line_in,
  output wire        serial_addr_line_out,
  output wire        serial_addr_line_oe_out,
  input  wire        output_drive_enable_n_in,
  output wire        output_drive_enable_n_out,
  output wire        output_drive_enable_n_oe_out,
  input  wire        frame_slot0_sync_in,
  output wire        frame_slot0_sync_out,
  output wire        frame_slot0_sync_oe_out
);

  localparam integer HALF_FULL = `TSP_BCLK_HALF - 1;
  localparam [2:0]   HALF_CNT  = HALF_FULL[2:0];

  // Shift one bit into a word in the selected order
  function [15:0] shift_in;
    input [15:0] word;
    input        bit_val;
    input        msb_first;
    begin
      if (msb_first) begin
        shift_in = {word[14:0], bit_val};
      end else begin
        shift_in = {bit_val, word[15:1]};
      end
    end
  endfunction

  // Next bit to leave a word in the selected order
  function pick_bit;
    input [15:0] word;
    input        msb_first;
    begin
      pick_bit = msb_first ? word[15] : word[0];
    end
  endfunction

  // Pin synchronisers: 0 din,1 ick,2 ild,3 ock,4 old,5 doen_n,6 sync,7 sadd
  reg  [7:0]  pin_s1_ff;
  reg  [7:0]  pin_s2_ff;
  wire [7:0]  pin_raw = {serial_addr_line_in, frame_slot0_sync_in,
                         output_drive_enable_n_in, output_word_strobe_in,
                         output_bit_clock_in, input_word_strobe_in,
                         input_bit_clock_in, serial_in_line_in};

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      // Pins idle high except frame sync, which idles low
      pin_s1_ff <= 8'hbf;
      pin_s2_ff <= 8'hbf;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Software state
  reg  [4:0]  ctrl_ff;
  reg  [7:0]  tdm_ff;
  reg  [15:0] tx_buf_ff;
  reg  [15:0] rx_buf_ff;
  reg  [15:0] saddr_ff;
  reg  [1:0]  status_ff;
  reg  [1:0]  mask_ff;
  reg         rxf_ff;
  reg         txe_ff;

  wire msb_first = ctrl_ff[`TSP_CTRL_MSB];
  wire ick_act   = ctrl_ff[`TSP_CTRL_ICK];
  wire ild_act   = ctrl_ff[`TSP_CTRL_ILD];
  wire ock_act   = ctrl_ff[`TSP_CTRL_OCK];
  wire old_act   = ctrl_ff[`TSP_CTRL_OLD];
  wire mp_mode   = tdm_ff[`TSP_TDM_MODE];
  wire sync_mst  = tdm_ff[`TSP_TDM_SYNC];
  wire [3:0] my_slot = sync_mst ? 4'h0 : tdm_ff[`TSP_TDM_SLOT_HI:`TSP_TDM_SLOT_LO];

  // Active bit clock and word strobe generator
  reg  [2:0]  gen_half_ff;
  reg         gen_bclk_ff;
  reg  [3:0]  gen_bit_ff;
  reg  [3:0]  gen_word_ff;
  reg         gen_sync_ff;
  wire        gen_strobe = (gen_bit_ff != 4'h0);
  wire [3:0]  frame_top  = tdm_ff[`TSP_TDM_SYNC_DIVIDE_SELECT] ? `TSP_FRAME_LONG : `TSP_FRAME_SHORT;

  // Effective link signals, generated or sampled
  wire ick_eff  = ick_act  ? gen_bclk_ff : pin_s2_ff[1];
  wire ild_eff  = ild_act  ? gen_strobe  : pin_s2_ff[2];
  wire ock_eff  = ock_act  ? gen_bclk_ff : pin_s2_ff[3];
  wire old_eff  = old_act  ? gen_strobe  : pin_s2_ff[4];
  wire sync_eff = sync_mst ? gen_sync_ff : pin_s2_ff[6];

  reg  [3:0]  prev_ff;
  wire        ick_rise  = ick_eff & ~prev_ff[0];
  wire        ild_fall  = ~ild_eff & prev_ff[1];
  wire        ock_rise  = ock_eff & ~prev_ff[2];
  wire        old_fall  = ~old_eff & prev_ff[3];
  reg         sync_d_ff;
  wire        sync_fall = ~sync_eff & sync_d_ff;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      prev_ff   <= 4'hf;
      sync_d_ff <= 1'b0;
    end else begin
      prev_ff   <= {old_eff, ock_eff, ild_eff, ick_eff};
      sync_d_ff <= sync_eff;
    end
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      gen_half_ff <= 3'h0;
      gen_bclk_ff <= 1'b1;
      gen_bit_ff  <= 4'hf;
      gen_word_ff <= 4'h0;
      gen_sync_ff <= 1'b1;
    end else if (sync_fall && !sync_mst) begin
      gen_half_ff <= HALF_CNT;
      gen_bclk_ff <= 1'b1;
      gen_bit_ff  <= 4'hf;
      gen_word_ff <= frame_top;
    end else if (gen_half_ff == HALF_CNT) begin
      gen_half_ff <= 3'h0;
      gen_bclk_ff <= ~gen_bclk_ff;
      if (gen_bclk_ff) begin
        gen_bit_ff <= gen_bit_ff + 4'h1;
        if (gen_bit_ff == 4'hf) begin
          gen_word_ff <= (gen_word_ff >= frame_top) ? 4'h0 : gen_word_ff + 4'h1;
          gen_sync_ff <= (gen_word_ff >= frame_top) ? 1'b0 : 1'b1;
        end
      end
    end else begin
      gen_half_ff <= gen_half_ff + 3'h1;
    end
  end

  // Time slot tracking, slot zero on frame sync
  reg  [3:0]  slot_ff;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      slot_ff <= 4'hf;
    end else if (sync_fall) begin
      slot_ff <= 4'h0;
    end else if (old_fall) begin
      slot_ff <= slot_ff + 4'h1;
    end
  end

  // Receive path
  reg  [15:0] isr_ff;
  reg  [4:0]  rx_cnt_ff;
  wire        rx_load = ick_rise && (rx_cnt_ff == `TSP_WORD_BITS - 5'h1);

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      isr_ff    <= 16'h0000;
      rx_cnt_ff <= `TSP_WORD_BITS;
      rx_buf_ff <= 16'h0000;
    end else begin
      if (ild_fall) begin
        rx_cnt_ff <= 5'h00;
      end else if (ick_rise && rx_cnt_ff != `TSP_WORD_BITS) begin
        isr_ff    <= shift_in(isr_ff, pin_s2_ff[0], msb_first);
        rx_cnt_ff <= rx_cnt_ff + 5'h01;
      end
      if (rx_load) begin
        rx_buf_ff <= shift_in(isr_ff, pin_s2_ff[0], msb_first);
      end
    end
  end

  // Transmit path
  reg  [15:0] osr_ff;
  reg  [15:0] asr_ff;
  reg  [4:0]  tx_cnt_ff;
  reg         tx_live_ff;
  reg         dout_ff;
  reg         aout_ff;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      osr_ff     <= 16'h0000;
      asr_ff     <= 16'h0000;
      tx_cnt_ff  <= `TSP_WORD_BITS;
      tx_live_ff <= 1'b0;
      dout_ff    <= 1'b0;
      aout_ff    <= 1'b1;
    end else if (old_fall) begin
      osr_ff     <= tx_buf_ff;
      asr_ff     <= saddr_ff;
      tx_cnt_ff  <= 5'h00;
      tx_live_ff <= 1'b1;
    end else if (ock_rise) begin
      if (tx_cnt_ff != `TSP_WORD_BITS) begin
        dout_ff   <= pick_bit(osr_ff, msb_first);
        aout_ff   <= ~pick_bit(asr_ff, msb_first);
        osr_ff    <= msb_first ? {osr_ff[14:0], 1'b0} : {1'b0, osr_ff[15:1]};
        asr_ff    <= msb_first ? {asr_ff[14:0], 1'b0} : {1'b0, asr_ff[15:1]};
        tx_cnt_ff <= tx_cnt_ff + 5'h01;
      end else begin
        tx_live_ff <= 1'b0;
      end
    end
  end

  // Pin drive
  wire my_turn  = mp_mode && tx_live_ff && (slot_ff == my_slot);
  wire doen_low = mp_mode ? my_turn : ~pin_s2_ff[5];
  wire line_en  = doen_low;

  assign input_bit_clock_out          = gen_bclk_ff;
  assign input_bit_clock_oe_out       = ick_act;
  assign input_word_strobe_out        = gen_strobe;
  assign input_word_strobe_oe_out     = ild_act;
  assign output_bit_clock_out         = gen_bclk_ff;
  assign output_bit_clock_oe_out      = ock_act;
  assign output_word_strobe_out       = gen_strobe;
  assign output_word_strobe_oe_out    = old_act;
  assign serial_out_line_out          = dout_ff;
  assign serial_out_line_oe_out       = line_en;
  assign serial_addr_line_out         = aout_ff;
  assign serial_addr_line_oe_out      = mp_mode ? my_turn : line_en;
  assign output_drive_enable_n_out    = 1'b0;
  assign output_drive_enable_n_oe_out = my_turn;
  assign frame_slot0_sync_out         = gen_sync_ff;
  assign frame_slot0_sync_oe_out      = sync_mst;

  // Register port
  wire wr_data  = reg_wr_in && (reg_addr_in == `TSP_ADDR_DATA);
  wire rd_data  = reg_rd_in && (reg_addr_in == `TSP_ADDR_DATA);
  wire wr_stat  = reg_wr_in && (reg_addr_in == `TSP_ADDR_STATUS);
  wire [1:0] ev = {old_fall, rx_load};

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_ff   <= `TSP_CTRL_RST;
      tdm_ff    <= `TSP_TDM_RST;
      tx_buf_ff <= 16'h0000;
      saddr_ff  <= 16'hffff;
      mask_ff   <= `TSP_MASK_RST;
      status_ff <= 2'h0;
      rxf_ff    <= 1'b0;
      txe_ff    <= 1'b1;
    end else begin
      if (reg_wr_in && reg_addr_in == `TSP_ADDR_CTRL) begin
        ctrl_ff <= reg_wdata_in[4:0];
      end
      if (reg_wr_in && reg_addr_in == `TSP_ADDR_TDM) begin
        tdm_ff <= reg_wdata_in[7:0];
      end
      if (reg_wr_in && reg_addr_in == `TSP_ADDR_SADDR) begin
        saddr_ff <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `TSP_ADDR_MASK) begin
        mask_ff <= reg_wdata_in[1:0];
      end
      if (wr_data) begin
        tx_buf_ff <= reg_wdata_in;
      end
      // Events win over write-one clears
      status_ff <= (status_ff & ~(wr_stat ? reg_wdata_in[1:0] : 2'h0)) | ev;
      if (rx_load) begin
        rxf_ff <= 1'b1;
      end else if (rd_data) begin
        rxf_ff <= 1'b0;
      end
      // Write in the transfer cycle leaves fresh data pending
      if (wr_data) begin
        txe_ff <= 1'b0;
      end else if (old_fall) begin
        txe_ff <= 1'b1;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `TSP_ADDR_CTRL:   reg_rdata_out <= {11'h000, ctrl_ff};
        `TSP_ADDR_TDM:    reg_rdata_out <= {8'h00, tdm_ff};
        `TSP_ADDR_DATA:   reg_rdata_out <= rx_buf_ff;
        `TSP_ADDR_SADDR:  reg_rdata_out <= saddr_ff;
        `TSP_ADDR_STATUS: reg_rdata_out <= {12'h000, txe_ff, rxf_ff, status_ff};
        `TSP_ADDR_MASK:   reg_rdata_out <= {14'h0000, mask_ff};
        default:          reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  assign irq_out             = |(status_ff & mask_ff);
  assign rx_buffer_full_out  = rxf_ff;
  assign tx_buffer_empty_out = txe_ff;

endmodule

// ===== core/tsp_map.vh
// Purpose: Register map, fields and timing for the TDM serial port
// Assumes: Word-addressed plain register port, 50 MHz core clock
// Notes:   Included by the serial port core only
`ifndef TSP_MAP_VH
`define TSP_MAP_VH
`define TSP_AW            3
`define TSP_ADDR_CTRL     3'h0
`define TSP_ADDR_TDM      3'h1
`define TSP_ADDR_DATA     3'h2
`define TSP_ADDR_SADDR    3'h3
`define TSP_ADDR_STATUS   3'h4
`define TSP_ADDR_MASK     3'h5
// Control fields
`define TSP_CTRL_MSB      0
`define TSP_CTRL_ICK      1
`define TSP_CTRL_ILD      2
`define TSP_CTRL_OCK      3
`define TSP_CTRL_OLD      4
// Time-division fields
`define TSP_TDM_MODE      0
`define TSP_TDM_SYNC      1
`define TSP_TDM_SYNC_DIVIDE_SELECT    2
`define TSP_TDM_SLOT_LO   4
`define TSP_TDM_SLOT_HI   7
// Status and mask fields
`define TSP_ST_RX         0
`define TSP_ST_TX         1
`define TSP_ST_RXF        2
`define TSP_ST_TXE        3
// Reset values
`define TSP_CTRL_RST      5'h00
`define TSP_TDM_RST       8'h00
`define TSP_MASK_RST      2'h0
// Word and frame sizes
`define TSP_WORD_BITS     5'h10
`define TSP_FRAME_SHORT   4'h7
`define TSP_FRAME_LONG    4'hf
// Active bit clock timing
`define TSP_CLK_NS        20
`define TSP_BCLK_NS       160
`define TSP_BCLK_HALF     (`TSP_BCLK_NS / (2 * `TSP_CLK_NS))
`endif

// ===== dv/tsp_properties.sv
// Purpose: Port-level checks for the serial port
// Assumes: Bound to tsp_serial_port, active bit clock half period of 4 clocks
// Notes:   Clock-enable based properties are muted while the pin is passive
`timescale 1ns/1ns
module tsp_properties (
  input wire       clk_in,
  input wire       resetn_in,
  input wire [2:0] reg_addr_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire       rx_buffer_full_out,
  input wire       tx_buffer_empty_out,
  input wire       output_bit_clock_out,
  input wire       output_bit_clock_oe_out,
  input wire       serial_out_line_oe_out,
  input wire       serial_addr_line_oe_out,
  input wire       output_drive_enable_n_in,
  input wire       output_drive_enable_n_out,
  input wire       output_drive_enable_n_oe_out,
  input wire       frame_slot0_sync_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  reset_flags_a: assert property ($rose(resetn_in) |-> tx_buffer_empty_out && !rx_buffer_full_out)
    else $error("flags wrong after reset");
  tx_write_clear_a: assert property (reg_wr_in && reg_addr_in == 3'h2 |=> !tx_buffer_empty_out)
    else $error("tx empty not cleared by write");
  rx_read_clear_a: assert property (reg_rd_in && reg_addr_in == 3'h2 |=> !rx_buffer_full_out)
    else $error("rx full not cleared by read");
  oe_pair_a: assert property (serial_out_line_oe_out == serial_addr_line_oe_out)
    else $error("data and address enables differ");
  enable_block_a: assert property (output_drive_enable_n_in [*5] |-> !serial_out_line_oe_out || output_drive_enable_n_oe_out)
    else $error("data driven while enable high");
  en_drive_low_a: assert property (output_drive_enable_n_oe_out |-> !output_drive_enable_n_out)
    else $error("slot marker not driven low");
  obclk_half_a: assert property (disable iff (!resetn_in || !output_bit_clock_oe_out)
    $rose(output_bit_clock_out) |-> output_bit_clock_out [*4] ##1 !output_bit_clock_out)
    else $error("active bit clock half period wrong");
  sync_oe_src_a: assert property ($changed(frame_slot0_sync_oe_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 3'h1)
    else $error("sync drive changed without write");
  mp_addr_a: assert property (output_drive_enable_n_oe_out |-> serial_addr_line_oe_out)
    else $error("address not driven in own slot");
endmodule
bind tsp_serial_port tsp_properties tsp_properties_inst (
  .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .rx_buffer_full_out(rx_buffer_full_out),
  .tx_buffer_empty_out(tx_buffer_empty_out), .output_bit_clock_out(output_bit_clock_out),
  .output_bit_clock_oe_out(output_bit_clock_oe_out), .serial_out_line_oe_out(serial_out_line_oe_out),
  .serial_addr_line_oe_out(serial_addr_line_oe_out),
  .output_drive_enable_n_in(output_drive_enable_n_in),
  .output_drive_enable_n_out(output_drive_enable_n_out),
  .output_drive_enable_n_oe_out(output_drive_enable_n_oe_out),
  .frame_slot0_sync_oe_out(frame_slot0_sync_oe_out));

// ===== dv/tsp_far_end.sv
// Purpose: Far-end serial device feeding and capturing words
// Assumes: Bit clock and strobes supplied by the port in active mode
// Notes:   Released data line toggles so stale bits are never seen
`timescale 1ns/1ns
module tsp_far_end (
  input  wire        clk_in,
  input  wire        msb_in,
  input  wire [15:0] word_in,
  input  wire        ibclk_in,
  input  wire        istrobe_in,
  input  wire        obclk_in,
  input  wire        ostrobe_in,
  input  wire        sout_in,
  input  wire        saddr_in,
  output reg         sdata_out,
  output reg  [15:0] data_out,
  output reg  [15:0] addr_out,
  output reg         done_out
);
  reg       ib_q, is_q, ob_q, os_q;
  reg [4:0] icnt, ocnt;
  initial begin
    {ib_q, is_q, ob_q, os_q, sdata_out, done_out} = 6'h00;
    {icnt, ocnt} = 10'h210;
    {data_out, addr_out} = 32'h0000_0000;
  end
  always @(posedge clk_in) begin
    {ib_q, is_q, ob_q, os_q} <= {ibclk_in, istrobe_in, obclk_in, ostrobe_in};
    done_out <= 1'b0;
    // Bits change on falling clock, stable at the sampling rise
    if (is_q && !istrobe_in) begin
      sdata_out <= msb_in ? word_in[15] : word_in[0];
      icnt <= 5'h01;
    end else if (ib_q && !ibclk_in) begin
      sdata_out <= icnt[4] ? ~sdata_out : word_in[msb_in ? ~icnt[3:0] : icnt[3:0]];
      icnt <= icnt + {4'h0, !icnt[4]};
    end
    if (ob_q && !obclk_in && !ocnt[4]) begin
      data_out <= msb_in ? {data_out[14:0], sout_in} : {sout_in, data_out[15:1]};
      addr_out <= msb_in ? {addr_out[14:0], ~saddr_in} : {~saddr_in, addr_out[15:1]};
      ocnt <= ocnt + 5'h01;
      done_out <= ocnt == 5'h0f;
    end
    if (os_q && !ostrobe_in) ocnt <= 5'h00;
  end
endmodule

// ===== dv/tsp_serial_port_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Far end answers in active mode, 50 MHz clock
// Notes:   Frame sync input held low unless the port drives it
`timescale 1ns/1ns
module tsp_serial_port_tb;
  reg         clk_in = 1'b0;
  reg         resetn_in = 1'b0;
  reg  [2:0]  addr = 3'h0;
  reg  [15:0] wdata = 16'h0000;
  reg         wr_s = 1'b0;
  reg         rd_s = 1'b0;
  reg         en_n = 1'b1;
  reg         msb = 1'b0;
  reg  [15:0] far_word = 16'h0000;
  wire [15:0] rdata, far_data, far_addr;
  wire        irq, rxf, txe, sdi, done, input_bitclk_source, ick_oe, input_strobe_source, ild_oe, output_bitclk_source, ock_oe, old, old_oe;
  wire        sdo, sdo_oe, sa, sa_oe, en_o, en_oe, fs, fs_oe;
  wire        ick_w = ick_oe ? input_bitclk_source : 1'b1;
  wire        ild_w = ild_oe ? input_strobe_source : 1'b1;
  wire        ock_w = ock_oe ? output_bitclk_source : 1'b1;
  wire        old_w = old_oe ? old : 1'b1;
  wire        sa_w = sa_oe ? sa : 1'b1;
  wire        en_w = en_oe ? en_o : en_n;
  wire        fs_w = fs_oe ? fs : 1'b0;
  wire [4:0]  ev = {fs_w, en_oe, done, rxf, txe};
  integer     errors = 0, checks = 0, waited;
  always #10 clk_in = ~clk_in;
  tsp_serial_port tsp_serial_port_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .irq_out(irq), .rx_buffer_full_out(rxf), .tx_buffer_empty_out(txe),
    .serial_in_line_in(sdi), .input_bit_clock_in(ick_w), .input_bit_clock_out(input_bitclk_source),
    .input_bit_clock_oe_out(ick_oe), .input_word_strobe_in(ild_w), .input_word_strobe_out(input_strobe_source),
    .input_word_strobe_oe_out(ild_oe), .output_bit_clock_in(ock_w), .output_bit_clock_out(output_bitclk_source),
    .output_bit_clock_oe_out(ock_oe), .output_word_strobe_in(old_w),
    .output_word_strobe_out(old), .output_word_strobe_oe_out(old_oe),
    .serial_out_line_out(sdo), .serial_out_line_oe_out(sdo_oe), .serial_addr_line_in(sa_w),
    .serial_addr_line_out(sa), .serial_addr_line_oe_out(sa_oe), .output_drive_enable_n_in(en_w),
    .output_drive_enable_n_out(en_o), .output_drive_enable_n_oe_out(en_oe),
    .frame_slot0_sync_in(fs_w), .frame_slot0_sync_out(fs), .frame_slot0_sync_oe_out(fs_oe));
  tsp_far_end tsp_far_end_inst (.clk_in(clk_in), .msb_in(msb), .word_in(far_word),
    .ibclk_in(ick_w), .istrobe_in(ild_w), .obclk_in(ock_w), .ostrobe_in(old_w),
    .sout_in(sdo_oe ? sdo : ~sdo), .saddr_in(sa_w), .sdata_out(sdi), .data_out(far_data),
    .addr_out(far_addr), .done_out(done));
  task results;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
      #1;
    end
  endtask
  task rdchk(input [2:0] a, input [15:0] exp, input use_it);
    begin
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      #1;
      if (use_it) chk(rdata, exp);
    end
  endtask
  task wait_ev(input integer k, input lv, input integer lim);
    begin
      for (waited = 0; waited < lim && ev[k] !== lv; waited = waited + 1) @(negedge clk_in);
      if (ev[k] !== lv) begin
        errors = errors + 1;
        $display("wrong value at %0t: event %h stuck at %h", $time, k, ev[k]);
        results;
      end
    end
  endtask
  task period(input integer n);
    integer w;
    begin
      wait_ev(4, 1'b1, 2200);
      wait_ev(4, 1'b0, 2200);
      wait_ev(4, 1'b1, 2200);
      w = waited;
      wait_ev(4, 1'b0, 2200);
      chk(w + waited, n);
    end
  endtask
  task t_reset;
    begin
      rdchk(3'h0, 16'h0000, 1'b1);
      rdchk(3'h1, 16'h0000, 1'b1);
      rdchk(3'h3, 16'hffff, 1'b1);
      rdchk(3'h4, 16'h0008, 1'b1);
      rdchk(3'h5, 16'h0000, 1'b1);
      rdchk(3'h6, 16'h0000, 1'b1);
      chk({14'h0000, rxf, txe}, 16'h0001);
    end
  endtask
  task t_loop(input m);
    begin
      msb = m;
      far_word = m ? 16'ha5c3 : 16'h3c5a;
      @(posedge clk_in);
      en_n <= 1'b0;
      wr(3'h3, m ? 16'h8e01 : 16'h1234);
      wr(3'h0, {11'h000, 4'hf, m});
      wr(3'h2, m ? 16'h3ffe : 16'hc001);
      chk({15'h0000, txe}, 16'h0000);
      wait_ev(0, 1'b1, 300);
      // Skip the word that ends as the transfer starts
      wait_ev(2, 1'b0, 300);
      wait_ev(2, 1'b1, 300);
      chk(far_data, m ? 16'h3ffe : 16'hc001);
      chk(far_addr, m ? 16'h8e01 : 16'h1234);
      wait_ev(1, 1'b1, 300);
      rdchk(3'h2, 16'h0000, 1'b0);
      wait_ev(1, 1'b1, 300);
      rdchk(3'h2, far_word, 1'b1);
      chk({15'h0000, rxf}, 16'h0000);
      @(posedge clk_in);
      en_n <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk({15'h0000, sdo_oe}, 16'h0000);
      wr(3'h0, 16'h0000);
    end
  endtask
  task t_irq;
    begin
      rdchk(3'h2, 16'h0000, 1'b0);
      wr(3'h5, 16'h0003);
      chk({15'h0000, irq}, 16'h0001);
      wr(3'h5, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      wr(3'h4, 16'h0003);
      rdchk(3'h4, 16'h0008, 1'b1);
      wr(3'h5, 16'h0003);
      chk({15'h0000, irq}, 16'h0000);
    end
  endtask
  task t_sync;
    begin
      wr(3'h0, 16'h001e);
      wr(3'h1, 16'h0002);
      chk({15'h0000, fs_oe}, 16'h0001);
      period(1024);
      wr(3'h1, 16'h0006);
      period(2048);
      wr(3'h1, 16'h0003);
      wait_ev(3, 1'b1, 2200);
      wait_ev(3, 1'b0, 300);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset;
    t_loop(1'b0);
    t_loop(1'b1);
    t_irq;
    t_sync;
    results;
  end
endmodule
